// [hw/txdc_seq.sv]
// transmit dc offset calibration sequencer
//
// Functional notes
// - external transmitter is steered over pass-through port, chip select one.
// - measure pin read on aux adc channel two; references read before drive.
// - I and Q dc levels move so error reading meets reference reading.
// - correction scaled by programmable gain; programmable iteration count.
// - first error readings taken with transmitter in low gain.
// - low to high gain switch adds fixed offset to I and Q levels.
// - setup initialises serial port and adc, selects in-phase reference.
// - read I ref, select Q ref; read Q ref, select I error.
// - low gain: read I error, adjust I, then Q error, adjust Q.
// - after low gain Q adjust, settle then loop to I error if left.
// - high gain: read Q error, adjust Q first, then I.
// - after high gain I adjust, settle then loop to Q error if left.
// - tidy-up restores transmitter to its pre-calibration configuration.
// - transmit-done flag set when calibration completes.
// - every stage duration is programmable.
// - setup and tidy always run; gain switch runs with any high stage.
// - ramp dac is held off throughout calibration.
// - calibration starts from transmit sequence or standalone.
// - resulting I and Q offsets are kept and readable.
`timescale 1ns/1ps
module txdc_seq (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic link_clk,
    input wire logic cal_start_seq,
    input wire logic cal_start_alone,
    input wire logic [7:0] stage_enable,
    input wire logic [159:0] stage_dwell,
    input wire logic [txdc_pkg::TXDC_GAIN_W-1:0] gain_factor,
    input wire logic [txdc_pkg::TXDC_ITER_W-1:0] lo_iterations,
    input wire logic [txdc_pkg::TXDC_ITER_W-1:0] hi_iterations,
    input wire logic [txdc_pkg::TXDC_DC_W-1:0] gain_switch_offset_i,
    input wire logic [txdc_pkg::TXDC_DC_W-1:0] gain_switch_offset_q,
    input wire logic [txdc_pkg::TXDC_SPI_W-1:0] tx_restore_word,
    input wire logic adc_done,
    input wire logic [txdc_pkg::TXDC_ADC_W-1:0] adc_data,
    input wire logic tx_done_clear,
    output logic [1:0] adc_channel,
    output logic adc_enable,
    output logic adc_start,
    output logic [txdc_pkg::TXDC_DC_W-1:0] i_dc_level,
    output logic [txdc_pkg::TXDC_DC_W-1:0] q_dc_level,
    output logic cal_busy,
    output logic cal_in_sequence,
    output logic seq_cal_done,
    output logic tx_done_flag,
    output logic ramp_dac_inhibit,
    output logic passthru_chip_select_one_n,
    output logic spi_sclk,
    output logic spi_mosi
);
    import txdc_pkg::*;

    txdc_stage_t stage_q;
    txdc_step_t step_q;
    logic [TXDC_ADC_W-1:0] ref_i_q, ref_q_q;
    logic [TXDC_ITER_W-1:0] lo_cnt_q, hi_cnt_q;
    logic [TXDC_DWELL_W-1:0] dwell_q;
    logic [TXDC_SPI_W-1:0] word_q;
    logic req_q, ack_s1_q, ack_s2_q, ack_s3_q, ack_seen_q;
    logic ack_toggle;

    ////////////////////////////////////////////////////////////////////
    // helpers

    // one-hot to index, used for the dwell table
    function automatic logic [3:0] oh_index(input logic [9:0] oh);
        logic [3:0] idx;
        idx = 4'h0;
        for (int k = 0; k < TXDC_STAGES; k++) begin
            if (oh[k]) begin
                idx = 4'(k);
            end
        end
        return idx;
    endfunction

    // lowest enabled stage above the present one
    function automatic logic [9:0] next_enabled(input logic [9:0] cur,
                                                input logic [9:0] en);
        logic [9:0] above;
        above = en & ~((cur << 1) - 10'h001);
        return above & (~above + 10'h001);
    endfunction

    // damped step: level + (ref - meas) * gain / 16
    function automatic logic [11:0] damped(input logic [11:0] level,
                                           input logic [9:0] ref_v,
                                           input logic [9:0] meas,
                                           input logic [7:0] gain);
        logic signed [11:0] diff;
        logic signed [20:0] prod;
        diff = $signed({2'b00, ref_v}) - $signed({2'b00, meas});
        prod = diff * $signed({1'b0, gain});
        prod = prod >>> TXDC_GAIN_FRAC;
        return level + prod[11:0];
    endfunction

    ////////////////////////////////////////////////////////////////////
    // stage selection and sequencing decisions

    // setup and tidy always; gain switch forced by any high stage
    wire hi_any = stage_enable[5] | stage_enable[6];
    wire [9:0] en_w = {1'b1, stage_enable[6:5], hi_any | stage_enable[4],
                       stage_enable[3:0], 1'b1, 1'b0};
    wire start_any = cal_start_seq | cal_start_alone;
    wire loop_lo = (stage_q == TXDC_ERR_Q_LO) && (lo_cnt_q != 4'h0)
                   && stage_enable[2];
    wire loop_hi = (stage_q == TXDC_ERR_I_HI) && (hi_cnt_q != 4'h0)
                   && stage_enable[5];
    wire [9:0] next_w = loop_lo ? TXDC_ERR_I_LO :
                        loop_hi ? TXDC_ERR_Q_HI :
                        next_enabled(stage_q, en_w);
    wire needs_adc = |(stage_q & (TXDC_REF_I | TXDC_REF_Q | TXDC_ERR_I_LO
                     | TXDC_ERR_Q_LO | TXDC_ERR_Q_HI | TXDC_ERR_I_HI));

    // word that selects what the next stage reads; tidy restores
    wire [15:0] sel_w = (stage_q == TXDC_TIDY) ? tx_restore_word :
                        next_w[2] ? TXDC_SEL_REF_I :
                        next_w[3] ? TXDC_SEL_REF_Q :
                        next_w[4] ? TXDC_SEL_ERR_I_LO :
                        next_w[5] ? TXDC_SEL_ERR_Q_LO :
                        next_w[8] ? TXDC_SEL_ERR_I_HI :
                        (next_w[6] | next_w[7]) ? TXDC_SEL_ERR_Q_HI :
                        TXDC_SEL_REF_I;

    wire [3:0] dw_idx = oh_index(stage_q);
    wire [15:0] dwell_w = stage_dwell[dw_idx*TXDC_DWELL_W +: TXDC_DWELL_W];
    wire ack_event = (ack_s2_q == ack_s3_q) && (ack_s3_q != ack_seen_q);
    wire finish = (step_q == TXDC_DWELL) && (dwell_q == 16'h0000)
                  && (stage_q == TXDC_TIDY);

    ////////////////////////////////////////////////////////////////////
    // ack synchroniser from the link domain
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ack_s1_q <= 1'b0;
            ack_s2_q <= 1'b0;
            ack_s3_q <= 1'b0;
        end else begin
            ack_s1_q <= ack_toggle;
            ack_s2_q <= ack_s1_q;
            ack_s3_q <= ack_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // stage and step sequencer
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            stage_q <= TXDC_IDLE;
            step_q <= TXDC_MEAS;
            dwell_q <= TXDC_DWELL_RESET;
            lo_cnt_q <= TXDC_ITER_RESET;
            hi_cnt_q <= TXDC_ITER_RESET;
            req_q <= 1'b0;
            word_q <= 16'h0000;
            ack_seen_q <= 1'b0;
            adc_start <= 1'b0;
        end else begin
            adc_start <= 1'b0;
            unique case (1'b1)
                stage_q[0]: begin
                    if (start_any) begin
                        stage_q <= TXDC_SETUP;
                        step_q <= TXDC_MEAS;
                        lo_cnt_q <= lo_iterations;
                        hi_cnt_q <= hi_iterations;
                    end
                end
                default: begin
                    unique case (step_q)
                        TXDC_MEAS: begin
                            if (needs_adc) begin
                                adc_start <= 1'b1;
                                step_q <= TXDC_ADCW;
                            end else begin
                                word_q <= sel_w;
                                req_q <= ~req_q;
                                step_q <= TXDC_SPIW;
                            end
                        end
                        TXDC_ADCW: begin
                            if (adc_done) begin
                                word_q <= sel_w;
                                req_q <= ~req_q;
                                step_q <= TXDC_SPIW;
                            end
                        end
                        TXDC_SPIW: begin
                            if (ack_event) begin
                                ack_seen_q <= ack_s3_q;
                                dwell_q <= dwell_w;
                                step_q <= TXDC_DWELL;
                            end
                        end
                        TXDC_DWELL: begin
                            if (dwell_q != 16'h0000) begin
                                dwell_q <= dwell_q - 16'h0001;
                            end else begin
                                // settle delay done, move or loop back
                                stage_q <= finish ? TXDC_IDLE
                                                  : txdc_stage_t'(next_w);
                                step_q <= TXDC_MEAS;
                                if (loop_lo) begin
                                    lo_cnt_q <= lo_cnt_q - 4'h1;
                                end
                                if (loop_hi) begin
                                    hi_cnt_q <= hi_cnt_q - 4'h1;
                                end
                            end
                        end
                    endcase
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // measurements and dc level updates; levels persist after the run
    // so later transmissions reuse them, and a new run starts from them
    wire adc_take = (step_q == TXDC_ADCW) && adc_done;
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            ref_i_q <= 10'h000;
            ref_q_q <= 10'h000;
            i_dc_level <= TXDC_DC_RESET;
            q_dc_level <= TXDC_DC_RESET;
        end else if (adc_take) begin
            if (stage_q == TXDC_REF_I) begin
                ref_i_q <= adc_data;
            end
            if (stage_q == TXDC_REF_Q) begin
                ref_q_q <= adc_data;
            end
            if (stage_q == TXDC_ERR_I_LO || stage_q == TXDC_ERR_I_HI) begin
                i_dc_level <= damped(i_dc_level, ref_i_q, adc_data,
                                     gain_factor);
            end
            if (stage_q == TXDC_ERR_Q_LO || stage_q == TXDC_ERR_Q_HI) begin
                q_dc_level <= damped(q_dc_level, ref_q_q, adc_data,
                                     gain_factor);
            end
        end else if (stage_q == TXDC_GAIN_SW && step_q == TXDC_MEAS) begin
            i_dc_level <= i_dc_level + gain_switch_offset_i;
            q_dc_level <= q_dc_level + gain_switch_offset_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // status outputs; a new completion beats a same-cycle clear
    always_ff @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            cal_busy <= 1'b0;
            cal_in_sequence <= 1'b0;
            seq_cal_done <= 1'b0;
            tx_done_flag <= 1'b0;
            ramp_dac_inhibit <= 1'b0;
            adc_channel <= 2'h0;
            adc_enable <= 1'b0;
        end else begin
            cal_busy <= (stage_q != TXDC_IDLE) && !finish;
            ramp_dac_inhibit <= (stage_q != TXDC_IDLE) && !finish;
            seq_cal_done <= finish && cal_in_sequence;
            if (stage_q == TXDC_IDLE && start_any) begin
                cal_in_sequence <= cal_start_seq;
            end
            if (stage_q == TXDC_SETUP) begin
                adc_channel <= TXDC_ADC_CHANNEL;
                adc_enable <= 1'b1;
            end
            if (finish) begin
                tx_done_flag <= 1'b1;
            end else if (tx_done_clear) begin
                tx_done_flag <= 1'b0;
            end
        end
    end

    txdc_spi_link u_link (
        .link_clk(link_clk),
        .reset_n(reset_n),
        .req_toggle(req_q),
        .word(word_q),
        .ack_toggle(ack_toggle),
        .passthru_chip_select_one_n(passthru_chip_select_one_n),
        .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi)
    );

    ////////////////////////////////////////////////////////////////////
    // checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!reset_n);

    sequence cal_kick;
        (stage_q == TXDC_IDLE) && start_any;
    endsequence
    sequence link_send;
        (step_q == TXDC_SPIW) && $changed(req_q);
    endsequence

    setup_first_a: assert property (cal_kick |=> stage_q == TXDC_SETUP)
        else $error("calibration did not open with setup");
    adc_chan_a: assert property (adc_start |-> adc_channel == 2'h2)
        else $error("adc started off channel two");
    link_ack_a: assert property (link_send |-> ##[1:200] ack_event)
        else $error("pass-through word not acknowledged");
    gain_offset_a: assert property ((stage_q == TXDC_GAIN_SW
        && step_q == TXDC_MEAS) |=> i_dc_level == $past(i_dc_level)
        + $past(gain_switch_offset_i))
        else $error("gain switch offset not applied");
    i_source_a: assert property ($changed(i_dc_level) |->
        $past(stage_q == TXDC_ERR_I_LO || stage_q == TXDC_ERR_I_HI
        || stage_q == TXDC_GAIN_SW))
        else $error("I level moved outside an I stage");
    lo_loop_a: assert property ((finish == 1'b0) && loop_lo
        && step_q == TXDC_DWELL && dwell_q == 16'h0000
        |=> stage_q == TXDC_ERR_I_LO)
        else $error("low gain loop did not return");
    hi_loop_a: assert property (loop_hi && step_q == TXDC_DWELL
        && dwell_q == 16'h0000 |=> stage_q == TXDC_ERR_Q_HI)
        else $error("high gain loop did not return");
    done_flag_a: assert property (finish |=> tx_done_flag && !cal_busy)
        else $error("done flag missing at completion");
    ramp_hold_a: assert property (stage_q != TXDC_IDLE
        |=> ramp_dac_inhibit || $past(finish))
        else $error("ramp dac not held during calibration");
    tidy_last_a: assert property ($fell(cal_busy)
        |-> $past(stage_q == TXDC_TIDY, 2))
        else $error("run ended without tidy-up");

endmodule

// [hw/txdc_pkg.sv]
// constants and types shared by the transmit dc offset calibration sequencer
package txdc_pkg;

    // calibration stages, one-hot, in sequence order
    typedef enum logic [9:0] {
        TXDC_IDLE     = 10'h001,
        TXDC_SETUP    = 10'h002,
        TXDC_REF_I    = 10'h004,
        TXDC_REF_Q    = 10'h008,
        TXDC_ERR_I_LO = 10'h010,
        TXDC_ERR_Q_LO = 10'h020,
        TXDC_GAIN_SW  = 10'h040,
        TXDC_ERR_Q_HI = 10'h080,
        TXDC_ERR_I_HI = 10'h100,
        TXDC_TIDY     = 10'h200
    } txdc_stage_t;

    // steps inside one stage
    typedef enum logic [3:0] {
        TXDC_MEAS  = 4'h1,
        TXDC_ADCW  = 4'h2,
        TXDC_SPIW  = 4'h4,
        TXDC_DWELL = 4'h8
    } txdc_step_t;

    localparam int TXDC_STAGES = 10;
    localparam int TXDC_DWELL_W = 16;
    localparam int TXDC_ADC_W = 10;
    localparam int TXDC_DC_W = 12;
    localparam int TXDC_GAIN_W = 8;
    localparam int TXDC_GAIN_FRAC = 4;
    localparam int TXDC_SPI_W = 16;
    localparam int TXDC_ITER_W = 4;

    // aux adc channel used for the measurement pin
    localparam logic [1:0] TXDC_ADC_CHANNEL = 2'h2;

    // serial words that pick the measurement pin source and gain state
    localparam logic [15:0] TXDC_SEL_REF_I = 16'h8100;
    localparam logic [15:0] TXDC_SEL_REF_Q = 16'h8200;
    localparam logic [15:0] TXDC_SEL_ERR_I_LO = 16'h8300;
    localparam logic [15:0] TXDC_SEL_ERR_Q_LO = 16'h8400;
    localparam logic [15:0] TXDC_SEL_ERR_I_HI = 16'h8380;
    localparam logic [15:0] TXDC_SEL_ERR_Q_HI = 16'h8480;

    // values after reset, and the index of the last serial bit
    localparam logic [11:0] TXDC_DC_RESET = 12'h000;
    localparam logic [3:0] TXDC_ITER_RESET = 4'h0;
    localparam logic [15:0] TXDC_DWELL_RESET = 16'h0000;
    localparam logic [4:0] TXDC_BIT_LAST = 5'h0F;

endpackage

// [hw/txdc_spi_link.sv]
// serial pass-through shifter running on the link clock
`timescale 1ns/1ps
module txdc_spi_link (
    input wire logic link_clk,
    input wire logic reset_n,
    input wire logic req_toggle,
    input wire logic [txdc_pkg::TXDC_SPI_W-1:0] word,
    output logic ack_toggle,
    output logic passthru_chip_select_one_n,
    output logic spi_sclk,
    output logic spi_mosi
);
    import txdc_pkg::*;

    logic req_s1_q, req_s2_q, req_s3_q, seen_q, busy_q;
    logic [4:0] cnt_q;
    logic [TXDC_SPI_W-1:0] sh_q;

    // a request counts once the second and third stages agree
    wire req_new = (req_s2_q == req_s3_q) && (req_s3_q != seen_q);
    wire start = req_new && !busy_q;
    wire last_bit = busy_q && spi_sclk && (cnt_q == TXDC_BIT_LAST);

    ////////////////////////////////////////////////////////////////////
    // request synchroniser
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            req_s1_q <= 1'b0;
            req_s2_q <= 1'b0;
            req_s3_q <= 1'b0;
        end else begin
            req_s1_q <= req_toggle;
            req_s2_q <= req_s1_q;
            req_s3_q <= req_s2_q;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // msb first, data changes while the clock is low; the word is held
    // stable by the sender until the ack toggles, so it is safe to read
    always_ff @(posedge link_clk or negedge reset_n) begin
        if (!reset_n) begin
            seen_q <= 1'b0;
            busy_q <= 1'b0;
            cnt_q <= 5'h00;
            sh_q <= 16'h0000;
            ack_toggle <= 1'b0;
            passthru_chip_select_one_n <= 1'b1;
            spi_sclk <= 1'b0;
            spi_mosi <= 1'b0;
        end else if (start) begin
            seen_q <= req_s3_q;
            busy_q <= 1'b1;
            cnt_q <= 5'h00;
            sh_q <= word;
            passthru_chip_select_one_n <= 1'b0;
            spi_sclk <= 1'b0;
            spi_mosi <= word[TXDC_SPI_W-1];
        end else if (last_bit) begin
            busy_q <= 1'b0;
            spi_sclk <= 1'b0;
            passthru_chip_select_one_n <= 1'b1;
            ack_toggle <= ~ack_toggle;
        end else if (busy_q) begin
            spi_sclk <= ~spi_sclk;
            if (spi_sclk) begin
                cnt_q <= cnt_q + 5'h01;
                sh_q <= {sh_q[TXDC_SPI_W-2:0], 1'b0};
                spi_mosi <= sh_q[TXDC_SPI_W-2];
            end
        end
    end

endmodule

// [dv/txdc_tx_model.sv]
// far-side transmitter model: serial select port and measurement adc
`timescale 1ns/1ps
module txdc_tx_model #(
    parameter logic [9:0] REF_I = 10'h12C,
    parameter logic [9:0] REF_Q = 10'h0C8
) (
    input wire logic sys_clk,
    input wire logic reset_n,
    input wire logic passthru_chip_select_one_n,
    input wire logic spi_sclk,
    input wire logic spi_mosi,
    input wire logic adc_start,
    input wire logic [3:0] adc_lag,
    input wire logic [9:0] err_base_lo,
    input wire logic [9:0] err_base_hi,
    input wire logic [11:0] i_dc_level,
    input wire logic [11:0] q_dc_level,
    output logic adc_done,
    output logic [9:0] adc_data,
    output logic [15:0] sel_word,
    output int word_count
);
    logic [15:0] shift_q;
    logic [4:0] nbits = 5'h00;
    logic [9:0] base;
    logic [9:0] meas;
    logic [9:0] sample_q;
    int lag;
    ////////////////////////////////////////////////////////////////////////
    // msb first on rising sclk; a word counts only when all 16 bits came
    always @(posedge spi_sclk or posedge passthru_chip_select_one_n) begin
        if (passthru_chip_select_one_n) begin
            if (!reset_n) begin
                sel_word <= 16'h0000;
                word_count <= 0;
            end else if (nbits == 5'h10) begin
                sel_word <= shift_q;
                word_count <= word_count + 1;
            end
            nbits <= 5'h00;
        end else begin
            shift_q <= {shift_q[14:0], spi_mosi};
            nbits <= nbits + 5'h01;
        end
    end
    // pin level of the chosen source; q error picks up some in-phase crosstalk
    always_comb begin
        base = sel_word[7] ? err_base_hi : err_base_lo;
        case (sel_word[11:8])
            4'h1: meas = REF_I;
            4'h2: meas = REF_Q;
            4'h3: meas = base + i_dc_level[9:0];
            default: meas = base + q_dc_level[9:0] + {3'h0, i_dc_level[9:3]};
        endcase
    end
    // conversion takes adc_lag cycles; data churns while not valid
    always @(posedge sys_clk or negedge reset_n) begin
        if (!reset_n) begin
            adc_done <= 1'b0;
            adc_data <= 10'h000;
            lag <= 0;
        end else begin
            adc_done <= (lag == 1);
            adc_data <= (lag == 1) ? sample_q : ~adc_data;
            if (adc_start) begin
                lag <= int'(adc_lag);
                sample_q <= meas;
            end else if (lag > 0) begin
                lag <= lag - 1;
            end
        end
    end
endmodule

// [dv/tb.sv]
// self-checking bench for the transmit dc calibration sequencer
`timescale 1ns/1ps
module tb;
    import txdc_pkg::*;
    localparam logic [9:0] RI = 10'h12C;
    localparam logic [9:0] RQ = 10'h0C8;
    logic sys_clk = 0, link_clk = 0, reset_n = 0, cal_start_seq = 0;
    logic cal_start_alone = 0, tx_done_clear = 0, adc_done, adc_enable;
    logic adc_start, cal_busy, cal_in_sequence, seq_cal_done, tx_done_flag;
    logic ramp_dac_inhibit, cs_n, spi_sclk, spi_mosi, saw_done;
    logic [7:0] stage_enable = 8'h07, gain_factor = 8'h10;
    logic [159:0] stage_dwell = {10{16'h0003}};
    logic [3:0] lo_it = 4'h0, hi_it = 4'h0, lag = 4'h1;
    logic [11:0] osi = 12'h010, osq = 12'hFF0, i_lv, q_lv, ei, eq;
    logic [15:0] restore = 16'h0055, sel_word;
    logic [9:0] adc_data, bl = 10'h064, bh = 10'h096;
    logic [1:0] adc_channel;
    int bad_count = 0, n_checks = 0, word_count;
    txdc_seq u_txdc_seq (.sys_clk(sys_clk), .reset_n(reset_n),
        .link_clk(link_clk), .cal_start_seq(cal_start_seq),
        .cal_start_alone(cal_start_alone), .stage_enable(stage_enable),
        .stage_dwell(stage_dwell), .gain_factor(gain_factor),
        .lo_iterations(lo_it), .hi_iterations(hi_it),
        .gain_switch_offset_i(osi), .gain_switch_offset_q(osq),
        .tx_restore_word(restore), .adc_done(adc_done), .adc_data(adc_data),
        .tx_done_clear(tx_done_clear), .adc_channel(adc_channel),
        .adc_enable(adc_enable), .adc_start(adc_start), .i_dc_level(i_lv),
        .q_dc_level(q_lv), .cal_busy(cal_busy),
        .cal_in_sequence(cal_in_sequence), .seq_cal_done(seq_cal_done),
        .tx_done_flag(tx_done_flag), .ramp_dac_inhibit(ramp_dac_inhibit),
        .passthru_chip_select_one_n(cs_n), .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi));
    txdc_tx_model #(.REF_I(RI), .REF_Q(RQ)) u_txdc_tx_model (
        .sys_clk(sys_clk), .reset_n(reset_n),
        .passthru_chip_select_one_n(cs_n), .spi_sclk(spi_sclk),
        .spi_mosi(spi_mosi), .adc_start(adc_start), .adc_lag(lag),
        .err_base_lo(bl), .err_base_hi(bh), .i_dc_level(i_lv),
        .q_dc_level(q_lv), .adc_done(adc_done), .adc_data(adc_data),
        .sel_word(sel_word), .word_count(word_count));
    initial forever #10 sys_clk = ~sys_clk;
    // link clock unrelated in phase to the system clock
    initial begin
        #3;
        forever #6 link_clk = ~link_clk;
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        n_checks++;
        if (seen !== exp) begin
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
            bad_count++;
        end
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    // expected level after one damped correction, 12-bit wrap
    function automatic logic [11:0] upd(logic [11:0] lv, logic [9:0] rf,
        logic [9:0] b, logic [7:0] g);
        int d;
        d = (int'(rf) - int'(10'(b + lv[9:0]))) * int'(g);
        return lv + 12'(d >>> 4);
    endfunction
    // one run; a second start while busy must be dropped
    task automatic run_cal(input logic seq);
        int n;
        @(posedge sys_clk);
        #1 cal_start_seq = seq;
        cal_start_alone = !seq;
        @(posedge sys_clk);
        #1 cal_start_seq = 0;
        cal_start_alone = 0;
        n = 0;
        saw_done = 0;
        repeat (4) @(posedge sys_clk);
        #1 chk("busy", cal_busy, 1);
        chk("in_seq", cal_in_sequence, seq);
        chk("ramp_inhibit", ramp_dac_inhibit, 1);
        chk("adc_ch", adc_channel, TXDC_ADC_CHANNEL);
        chk("adc_en", adc_enable, 1);
        cal_start_alone = 1;
        @(posedge sys_clk);
        #1 cal_start_alone = 0;
        while (cal_busy === 1'b1 && n < 20000) begin
            @(posedge sys_clk);
            #1 n++;
            if (seq_cal_done === 1'b1) saw_done = 1;
        end
        if (n >= 20000) begin
            bad_count++;
            summarize();
        end
        repeat (5) @(posedge sys_clk);
        #1 chk("idle_after", cal_busy, 0);
        chk("ramp_after", ramp_dac_inhibit, 0);
        chk("done_flag", tx_done_flag, 1);
        chk("seq_done", saw_done, seq);
        chk("restore", sel_word, restore);
    endtask
    initial begin
        repeat (5) @(posedge sys_clk);
        #1 chk("rst_i", i_lv, TXDC_DC_RESET);
        chk("rst_cs", cs_n, 1);
        chk("rst_flag", tx_done_flag, 0);
        reset_n = 1;
        // short run: references and low-gain I only, zero loop count
        run_cal(0);
        ei = upd(12'h000, RI, bl, 8'h10);
        chk("i_lvl", i_lv, ei);
        chk("q_lvl", q_lv, 12'h000);
        chk("words", word_count, 5);
        $display("test short_run done");
        tx_done_clear = 1;
        @(posedge sys_clk);
        #1 tx_done_clear = 0;
        chk("flag_clr", tx_done_flag, 0);
        $display("test flag_clear done");
        // full run: gain switch left off but forced by high stages
        stage_enable = 8'h6F;
        gain_factor = 8'h08;
        lo_it = 4'h1;
        hi_it = 4'h1;
        lag = 4'h7;
        bl = 10'h03C;
        eq = 12'h000;
        run_cal(1);
        repeat (2) begin
            ei = upd(ei, RI, bl, 8'h08);
            eq = upd(eq, RQ, 10'(bl + ei[9:3]), 8'h08);
        end
        ei = ei + osi;
        eq = eq + osq;
        repeat (2) begin
            eq = upd(eq, RQ, 10'(bh + ei[9:3]), 8'h08);
            ei = upd(ei, RI, bh, 8'h08);
        end
        chk("i_full", i_lv, ei);
        chk("q_full", q_lv, eq);
        chk("words_full", word_count, 18);
        $display("test full_run done");
        summarize();
    end
endmodule
